// ==== core/sfh_pkg.sv ====
/*
  Shared constants, types and decode helpers for the serial flash host interface front end.
  Assumes one system clock; the serial pins arrive asynchronously and are synchronised inside the slave front end.
*/
package sfh_pkg;

  // Read-class opcodes
  localparam logic [7:0] OP_ARRAY_HS  = 8'h0b;
  localparam logic [7:0] OP_ARRAY_LF  = 8'h03;
  localparam logic [7:0] OP_ARRAY_LEG = 8'he8;
  localparam logic [7:0] OP_BUF1_LF   = 8'hd1;
  localparam logic [7:0] OP_BUF2_LF   = 8'hd3;
  localparam logic [7:0] OP_PROT      = 8'h32;
  localparam logic [7:0] OP_LOCK      = 8'h35;
  localparam logic [7:0] OP_STATUS    = 8'hd7;
  localparam logic [7:0] OP_IDENT     = 8'h9f;

  // Header bytes (address plus dummy) between opcode and first return byte
  localparam logic [2:0] HDR_ARRAY_HS  = 3'h4;
  localparam logic [2:0] HDR_ARRAY_LF  = 3'h3;
  localparam logic [2:0] HDR_ARRAY_LEG = 3'h7;
  localparam logic [2:0] HDR_BUF_LF    = 3'h3;
  localparam logic [2:0] HDR_REG       = 3'h3;
  localparam logic [2:0] HDR_NONE      = 3'h0;

  // Page size choices
  localparam logic [9:0] PAGE_BYTES_DEF = 10'h210;
  localparam logic [9:0] PAGE_BYTES_ALT = 10'h200;

  // Misc
  localparam logic [7:0] FILL_BYTE     = 8'h00;
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam int         FIFO_DEPTH_DEF = 8;
  localparam int         BYTE_W        = 8;

  typedef enum logic [2:0] {
    K_WRITE, K_ARRAY, K_BUF1, K_BUF2, K_PROT, K_LOCK, K_STATUS, K_IDENT
  } sfh_kind_t;

  typedef struct packed {
    logic cs_b;
    logic sck;
    logic si;
  } sfh_pins_t;

  typedef struct packed {
    logic [7:0] opcode;
    sfh_kind_t  kind;
  } sfh_cmd_t;

  function automatic sfh_kind_t sfh_decode(input logic [7:0] op);
    case (op)
      OP_ARRAY_HS, OP_ARRAY_LF, OP_ARRAY_LEG: sfh_decode = K_ARRAY;
      OP_BUF1_LF:                             sfh_decode = K_BUF1;
      OP_BUF2_LF:                             sfh_decode = K_BUF2;
      OP_PROT:                                sfh_decode = K_PROT;
      OP_LOCK:                                sfh_decode = K_LOCK;
      OP_STATUS:                              sfh_decode = K_STATUS;
      OP_IDENT:                               sfh_decode = K_IDENT;
      default:                                sfh_decode = K_WRITE;
    endcase
  endfunction

  function automatic logic [2:0] sfh_hdr_len(input logic [7:0] op);
    case (op)
      OP_ARRAY_HS:             sfh_hdr_len = HDR_ARRAY_HS;
      OP_ARRAY_LF:             sfh_hdr_len = HDR_ARRAY_LF;
      OP_ARRAY_LEG:            sfh_hdr_len = HDR_ARRAY_LEG;
      OP_BUF1_LF, OP_BUF2_LF:  sfh_hdr_len = HDR_BUF_LF;
      OP_PROT, OP_LOCK:        sfh_hdr_len = HDR_REG;
      default:                 sfh_hdr_len = HDR_NONE;
    endcase
  endfunction

endpackage

// ==== core/sfh_fifo.sv ====
/*
  Synchronous FIFO for return bytes, width and depth as parameters.
  Assumes both sides on the same clock; depth a power of two.
*/
`timescale 1ns/10ps
`default_nettype none

module sfh_fifo
  import sfh_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  // Drain side
  output var  logic             out_valid,
  output var  logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("sfh_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             rdy_reg, rdy_next;
  logic             push, pop;

  always_comb begin
    push     = in_valid && rdy_reg;
    pop      = out_ready && (cnt_reg != '0);
    wr_next  = push ? wr_reg + 1'b1 : wr_reg;
    rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // Registered ready keeps the port glitch free
    rdy_next = cnt_next != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  assign in_ready  = rdy_reg;
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem[rd_reg];

endmodule // sfh_fifo

`default_nettype wire

// ==== core/sfh_slave.sv ====
/*
  Device-side serial command front end: oversamples chip select, serial clock and serial
  input, decodes opcodes, forwards header and write bytes, shifts return bytes out.
  Assumes the system clock is at least eight times the serial clock; return data for
  array, buffer, protection and lockdown reads is pushed by the memory core into the FIFO.
*/
// Function
// - Commands work alike whether the serial clock idles low or high at select.
// - Compatible style: each output bit valid within the clock low phase.
// - High-speed style: output need not settle within the low phase.
// - Output shifts on falling serial clock edges, input sampled on rising edges.
// - Bytes move bitwise; input on rising edges, return bytes on falling edges.
// - Decode continuous array reads 0BH, 03H and legacy E8H.
// - Decode low-frequency buffer reads D1H and D3H.
// - Opcode 32H returns the sector protection register contents.
// - Opcode 35H returns the sector lockdown register contents.
// - Opcode D7H returns the status register contents.
// - Opcode 9FH returns maker and part identification bytes.
// - Page size comes up at 528 bytes, reconfigurable to 512 bytes.
`timescale 1ns/10ps
`default_nettype none

module sfh_slave
  import sfh_pkg::*;
#(
  parameter int          FIFO_DEPTH = FIFO_DEPTH_DEF,
  parameter logic [31:0] ID_CODE    = 32'h00112233 // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Serial pins
  input  wire sfh_pins_t   pins,
  output var  logic        so_out,
  output var  logic        so_oe,
  // Command side
  output var  logic        cmd_valid,
  output var  sfh_cmd_t    cmd,
  output var  logic        rx_valid,
  output var  logic [7:0]  rx_byte,
  output var  logic        cmd_end,
  // Return data
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  output var  logic        tx_ready,
  input  wire logic [7:0]  status_in,
  // Configuration and diagnostics
  input  wire logic        cfg_512,
  output var  logic [9:0]  page_bytes,
  output var  logic        underrun
);

  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_HDR, ST_SINK, ST_RESP} sfh_state_t;

  // Pin synchroniser
  sfh_pins_t  sync1_reg, sync2_reg;
  logic       sck_prev_reg, cs_prev_reg, si_prev_reg;

  // Protocol state
  sfh_state_t state_reg, state_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] hdr_reg, hdr_next;
  logic [7:0] tx_reg, tx_next;
  logic [2:0] txc_reg, txc_next;
  logic [1:0] idx_reg, idx_next;
  logic       so_reg, so_next, oe_reg, oe_next;
  sfh_cmd_t   cmd_reg, cmd_next;
  logic       cmd_valid_reg, cmd_valid_next;
  logic       rx_valid_reg, rx_valid_next;
  logic [7:0] rx_reg, rx_next;
  logic       end_reg, end_next;
  logic       und_reg, und_next;
  logic [9:0] page_reg, page_next;

  // Edge detection and FIFO hookup
  logic       cs_act, cs_fall, rise, fall, byte_done, load, pop;
  logic [7:0] byte_in;
  sfh_kind_t  kind_sel;
  logic       fifo_valid;
  logic [7:0] fifo_data;

  sfh_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (tx_valid),
    .in_data   (tx_data),
    .in_ready  (tx_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (pop)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg    <= '{cs_b: 1'b1, sck: 1'b0, si: 1'b0};
      sync2_reg    <= '{cs_b: 1'b1, sck: 1'b0, si: 1'b0};
      sck_prev_reg <= 1'b0;
      cs_prev_reg  <= 1'b1;
      si_prev_reg  <= 1'b0;
    end else begin
      sync1_reg    <= pins;
      sync2_reg    <= sync1_reg;
      sck_prev_reg <= sync2_reg.sck;
      cs_prev_reg  <= sync2_reg.cs_b;
      si_prev_reg  <= sync2_reg.si;
    end
  end

  // Edges count only once select is low, so the idle level at select is irrelevant
  always_comb begin
    cs_act    = !sync2_reg.cs_b;
    cs_fall   = cs_act && cs_prev_reg;
    rise      = cs_act && sync2_reg.sck && !sck_prev_reg;
    fall      = cs_act && !sync2_reg.sck && sck_prev_reg;
    // Input as it stood before the rise: the host may launch the next bit on it
    byte_in   = {shift_reg[6:0], si_prev_reg};
    byte_done = rise && (bit_reg == BIT_LAST) && !cs_fall;
    kind_sel  = (state_reg == ST_OPC) ? sfh_decode(byte_in) : cmd_reg.kind;
  end

  always_comb begin
    state_next     = state_reg;
    bit_next       = bit_reg;
    shift_next     = shift_reg;
    hdr_next       = hdr_reg;
    tx_next        = tx_reg;
    txc_next       = txc_reg;
    idx_next       = idx_reg;
    so_next        = so_reg;
    oe_next        = oe_reg;
    cmd_next       = cmd_reg;
    rx_next        = rx_reg;
    cmd_valid_next = 1'b0;
    rx_valid_next  = 1'b0;
    end_next       = 1'b0;
    und_next       = 1'b0;
    load           = 1'b0;
    pop            = 1'b0;
    page_next      = cfg_512 ? PAGE_BYTES_ALT : page_reg;
    if (!cs_act) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
      end_next   = state_reg != ST_IDLE;
    end else if (cs_fall) begin
      state_next = ST_OPC;
      bit_next   = '0;
      oe_next    = 1'b0;
    end else begin
      if (rise) begin
        shift_next = byte_in;
        bit_next   = bit_reg + 1'b1;
      end
      if (byte_done) begin
        case (state_reg)
          ST_OPC: begin
            cmd_next       = '{opcode: byte_in, kind: kind_sel};
            cmd_valid_next = 1'b1;
            hdr_next       = sfh_hdr_len(byte_in);
            idx_next       = '0;
            if (kind_sel == K_WRITE) begin
              state_next = ST_SINK;
            end else if (sfh_hdr_len(byte_in) == HDR_NONE) begin
              state_next = ST_RESP;
              load       = 1'b1;
            end else begin
              state_next = ST_HDR;
            end
          end
          ST_HDR: begin
            rx_next       = byte_in;
            rx_valid_next = 1'b1;
            hdr_next      = hdr_reg - 1'b1;
            if (hdr_reg == 3'h1) begin
              state_next = ST_RESP;
              load       = 1'b1;
            end
          end
          ST_SINK: begin
            rx_next       = byte_in;
            rx_valid_next = 1'b1;
          end
          default: begin
          end
        endcase
      end
      // Launch right after the falling edge: valid early in the low phase
      if (fall && state_reg == ST_RESP) begin
        oe_next  = 1'b1;
        so_next  = tx_reg[7];
        tx_next  = {tx_reg[6:0], 1'b0};
        txc_next = txc_reg + 1'b1;
        load     = txc_reg == BIT_LAST;
      end
      if (load) begin
        txc_next = '0;
        case (kind_sel)
          K_STATUS: tx_next = status_in;
          K_IDENT: begin
            // Index already restarted at the opcode, so every frame opens on the top byte
            tx_next  = ID_CODE[{~idx_next, 3'b000} +: 8];
            idx_next = idx_next + 1'b1;
          end
          default: begin
            // Protection and lockdown contents come through the FIFO too
            if (fifo_valid) begin
              tx_next = fifo_data;
              pop     = 1'b1;
            end else begin
              tx_next  = FILL_BYTE;
              und_next = 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= ST_IDLE;
      bit_reg       <= '0;
      shift_reg     <= '0;
      hdr_reg       <= '0;
      tx_reg        <= '0;
      txc_reg       <= '0;
      idx_reg       <= '0;
      so_reg        <= 1'b0;
      oe_reg        <= 1'b0;
      cmd_reg       <= '{opcode: 8'h00, kind: K_WRITE};
      rx_reg        <= '0;
      cmd_valid_reg <= 1'b0;
      rx_valid_reg  <= 1'b0;
      end_reg       <= 1'b0;
      und_reg       <= 1'b0;
      page_reg      <= PAGE_BYTES_DEF;
    end else begin
      state_reg     <= state_next;
      bit_reg       <= bit_next;
      shift_reg     <= shift_next;
      hdr_reg       <= hdr_next;
      tx_reg        <= tx_next;
      txc_reg       <= txc_next;
      idx_reg       <= idx_next;
      so_reg        <= so_next;
      oe_reg        <= oe_next;
      cmd_reg       <= cmd_next;
      rx_reg        <= rx_next;
      cmd_valid_reg <= cmd_valid_next;
      rx_valid_reg  <= rx_valid_next;
      end_reg       <= end_next;
      und_reg       <= und_next;
      page_reg      <= page_next;
    end
  end

  assign so_out     = so_reg;
  assign so_oe      = oe_reg;
  assign cmd_valid  = cmd_valid_reg;
  assign cmd        = cmd_reg;
  assign rx_valid   = rx_valid_reg;
  assign rx_byte    = rx_reg;
  assign cmd_end    = end_reg;
  assign underrun   = und_reg;
  assign page_bytes = page_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_opc_byte(logic [7:0] op);
    state_reg == ST_OPC && byte_done && byte_in == op;
  endsequence

  a_cs_release: assert property (!cs_act |=> !so_oe ##1 !so_oe)
    else $error("serial output driven with select high");
  a_select_start: assert property (cs_fall |=> state_reg == ST_OPC && bit_reg == 3'h0)
    else $error("select fall did not restart opcode capture");
  a_out_on_fall: assert property ((so_out != $past(so_out)) |-> $past(fall, 1))
    else $error("output bit changed without a falling edge");
  a_out_low_phase: assert property ($rose(so_oe) |-> !sck_prev_reg)
    else $error("output enabled outside clock low phase");
  a_in_on_rise: assert property ((bit_reg != $past(bit_reg)) |-> $past(rise | cs_fall))
    else $error("input bit counted without a rising edge");
  a_array_read: assert property (s_opc_byte(OP_ARRAY_LEG) |=> cmd_valid && cmd.kind == K_ARRAY
                                 ##1 state_reg == ST_HDR && hdr_reg == HDR_ARRAY_LEG)
    else $error("legacy array read not decoded");
  a_buf_read: assert property (s_opc_byte(OP_BUF2_LF) |=> cmd_valid && cmd.kind == K_BUF2
                               && state_reg == ST_HDR)
    else $error("buffer read not decoded");
  a_status_load: assert property (s_opc_byte(OP_STATUS) |=> state_reg == ST_RESP
                                  && tx_reg == $past(status_in))
    else $error("status byte not loaded");
  a_ident_load: assert property (s_opc_byte(OP_IDENT) |=> tx_reg == ID_CODE[31:24])
    else $error("first identification byte wrong");
  a_msb_first: assert property (rise && !cs_fall |=> shift_reg[0] == $past(si_prev_reg)
                                && shift_reg[7:1] == $past(shift_reg[6:0]))
    else $error("input not shifted msb first");
  a_page_size: assert property ((page_bytes != $past(page_bytes)) |->
                                $past(cfg_512) && page_bytes == PAGE_BYTES_ALT)
    else $error("page size changed without request");

endmodule // sfh_slave

`default_nettype wire

// ==== verification/sfh_host_model.sv ====
/*
  Host controller model: serial bus master making select, serial clock and serial input.
  Assumes a system clock eight times the serial clock it makes; frames are run by task call.
*/
`timescale 1ns/10ps
`default_nettype none

module sfh_host_model
  import sfh_pkg::*;
(
  // Clock
  input  wire logic      clock,
  // Serial pins
  output var  sfh_pins_t pins,
  input  wire logic      so_out,
  input  wire logic      so_oe
);
  // Page writing opcodes: plain defaults, kept outside the decoded read set
  localparam logic [7:0] PAGE_PROG_OP = 8'ha1;
  localparam logic [7:0] BUF_WR_OP    = 8'ha2;
  localparam logic [7:0] BUF_PROG_OP  = 8'ha3;
  localparam logic [7:0] REWRITE_OP   = 8'ha4;
  localparam int         SECTOR_PAGES = 8;
  localparam int         REFRESH_SPAN = 10000;

  logic line_reg = 1'b0;
  logic line;
  int   page_ptr = 0;
  int   ops_cnt  = 0;

  // Released line toggles, so stale data never reads as a match
  assign line = so_oe ? so_out : ~line_reg;
  always @(posedge clock) line_reg <= line;

  initial pins = '{cs_b: 1'b1, sck: 1'b0, si: 1'b0};

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One frame; each returned byte holds what the device launched while that byte was sent
  task automatic frame(input bit mode3, input logic [7:0] out_q[$],
                       output logic [7:0] in_q[$]);
    logic [7:0] b;
    int         nb;
    in_q = {};
    b    = '0;
    nb   = 0;
    @(posedge clock);
    pins.sck <= mode3;
    wait_clk(4);
    pins.cs_b <= 1'b0;
    pins.si   <= out_q[0][7];
    wait_clk(4);
    foreach (out_q[i]) begin
      for (int k = 7; k >= 0; k--) begin
        // Falling edge: take the bit launched one fall earlier
        if (i > 0 || k < 7) begin
          b = {b[6:0], line};
          nb++;
          if (nb % 8 == 0) in_q.push_back(b);
        end
        pins.sck <= 1'b0;
        wait_clk(4);
        pins.sck <= 1'b1;
        // Next bit leaves on this rise; the device takes it on the following one
        if (k > 0) pins.si <= out_q[i][k-1];
        else if (i + 1 < out_q.size()) pins.si <= out_q[i+1][7];
        wait_clk(4);
      end
    end
    b = {b[6:0], line};
    in_q.push_back(b);
    if (!mode3) pins.sck <= 1'b0;
    wait_clk(4);
    pins.cs_b <= 1'b1;
    wait_clk(8);
  endtask

  // Program a page directly or through a buffer, then rewrite the page the pointer names.
  // One rewrite per program refreshes a sector every SECTOR_PAGES operations.
  task automatic page_write(input bit mode3, input bit via_buf, input logic [15:0] page);
    logic [7:0] q[$];
    logic [7:0] r[$];
    if (via_buf) begin
      q = {BUF_WR_OP, 8'h00, 8'h00, 8'h00, page[7:0]};
      frame(mode3, q, r);
      q = {BUF_PROG_OP, 8'h00, page[15:8], page[7:0]};
    end else begin
      q = {PAGE_PROG_OP, 8'h00, page[15:8], page[7:0], page[7:0]};
    end
    frame(mode3, q, r);
    ops_cnt++;
    q = {REWRITE_OP, 8'h00, 8'(page_ptr >> 8), 8'(page_ptr)};
    frame(mode3, q, r);
    page_ptr = (page_ptr + 1) % SECTOR_PAGES;
  endtask
endmodule // sfh_host_model

`default_nettype wire

// ==== verification/testbench.sv ====
/*
  Self-checking bench for the serial command front end: reads of every kind, FIFO fill and
  drain, write-class stream, page size. Assumes the host model as the serial master.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench
  import sfh_pkg::*;
;
  localparam logic [31:0] ID_VAL = 32'h5a6b7c8d; // Arbitrary value
  localparam int          NRD    = 7;

  logic       clock;
  logic       rst_b;
  logic       tx_valid;
  logic       cfg_512;
  logic [7:0] tx_data;
  logic [7:0] status_in;
  sfh_pins_t  pins;
  logic       so_out;
  logic       so_oe;
  logic       cmd_valid;
  logic       rx_valid;
  logic       cmd_end;
  logic       tx_ready;
  logic       underrun;
  sfh_cmd_t   cmd;
  logic [7:0] rx_byte;
  logic [9:0] page_bytes;
  int         err_count = 0;
  int         total_checks = 0;
  int         under_cnt = 0;
  int         end_cnt = 0;
  int         cv_cnt = 0;
  int         oe_hits = 0;
  int         nframes = 0;
  logic [15:0] lfsr = 16'h1a37;
  logic [7:0] rx_log[$];
  logic [7:0] got[$];
  logic [7:0] sent[$];
  logic [7:0] data[$];
  logic [7:0] rd_op [NRD] = '{8'h0b, 8'h03, 8'he8, 8'hd1, 8'hd3, 8'h32, 8'h35};
  int         rd_hdr [NRD] = '{4, 3, 7, 3, 3, 3, 3};
  sfh_kind_t  rd_kind [NRD] = '{K_ARRAY, K_ARRAY, K_ARRAY, K_BUF1, K_BUF2, K_PROT, K_LOCK};

  sfh_slave #(.FIFO_DEPTH(8), .ID_CODE(ID_VAL)) DUT (
    .clock(clock), .rst_b(rst_b), .pins(pins), .so_out(so_out), .so_oe(so_oe),
    .cmd_valid(cmd_valid), .cmd(cmd), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .cmd_end(cmd_end), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .status_in(status_in), .cfg_512(cfg_512), .page_bytes(page_bytes), .underrun(underrun)
  );

  sfh_host_model host (.clock(clock), .pins(pins), .so_out(so_out), .so_oe(so_oe));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    if (rx_valid === 1'b1) rx_log.push_back(rx_byte);
    if (underrun === 1'b1) under_cnt++;
    if (cmd_end === 1'b1) end_cnt++;
    if (cmd_valid === 1'b1) cv_cnt++;
    if (so_oe === 1'b1) oe_hits++;
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction

  function automatic logic [7:0] id_byte(input int n);
    return ID_VAL[8*(3-n%4) +: 8];
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Valid held high across pushes; ends one edge after release
  task automatic push(input logic [7:0] q[$]);
    foreach (q[i]) begin
      tx_valid <= 1'b1;
      tx_data  <= q[i];
      do @(posedge clock); while (tx_ready !== 1'b1);
    end
    tx_valid <= 1'b0;
    @(posedge clock);
  endtask

  // Opcode, random header, then n random bytes while the answer comes back
  task automatic xfer(input bit m3, input logic [7:0] op, input int hdr, input int n);
    logic [7:0] q[$];
    logic [7:0] r[$];
    sent   = {};
    rx_log = {};
    q.push_back(op);
    for (int i = 0; i < hdr + n; i++) begin
      q.push_back(rnd());
      if (i < hdr) sent.push_back(q[i+1]);
    end
    host.frame(m3, q, r);
    nframes++;
    got = r[1+hdr:$];
    foreach (sent[i]) check("header byte", rx_log[i], sent[i]);
    check("header count", rx_log.size(), sent.size());
    check("output released", so_oe, 1'b0);
  endtask

  initial begin
    #2000000;
    err_count++;
    stop_test();
  end

  initial begin
    rst_b     = 1'b0;
    tx_valid  = 1'b0;
    tx_data   = 8'h00;
    cfg_512   = 1'b0;
    status_in = 8'h00;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    check("page size", page_bytes, 32'h210);
    check("fifo ready", tx_ready, 1'b1);
    check("output idle", so_oe, 1'b0);
    for (int m = 0; m < 2; m++) begin
      status_in <= rnd();
      @(posedge clock);
      xfer(m[0], 8'hd7, 0, 3);
      foreach (got[i]) check("status", got[i], status_in);
      check("status cmd", cmd, {8'hd7, K_STATUS});
      xfer(m[0], 8'h9f, 0, 5);
      foreach (got[i]) check("ident", got[i], id_byte(i));
    end
    for (int i = 0; i < NRD; i++) begin
      data = {rnd(), rnd()};
      push(data);
      xfer(i[0], rd_op[i], rd_hdr[i], 2);
      check("read kind", cmd, {rd_op[i], rd_kind[i]});
      foreach (data[j]) check("read data", got[j], data[j]);
    end
    // Empty FIFO: filler byte and underrun flag
    under_cnt = 0;
    xfer(1'b0, 8'h03, 3, 1);
    check("fill byte", got[0], 8'h00);
    check("underrun seen", under_cnt > 0, 1'b1);
    // Fill until refused, a refused push, then drain one past empty
    data = {};
    repeat (8) data.push_back(rnd());
    push(data);
    repeat (2) @(posedge clock);
    check("fifo full", tx_ready, 1'b0);
    tx_valid <= 1'b1;
    tx_data  <= rnd();
    repeat (3) @(posedge clock);
    tx_valid <= 1'b0;
    xfer(1'b1, 8'h0b, 4, 9);
    foreach (data[j]) check("drain data", got[j], data[j]);
    check("refused byte", got[8], 8'h00);
    check("ready again", tx_ready, 1'b1);
    // Write class: bytes stream in, output stays released
    oe_hits = 0;
    xfer(1'b0, 8'h82, 3, 0);
    check("write kind", cmd.kind, K_WRITE);
    check("write output", oe_hits, 0);
    // Page programs through the host, each followed by a rewrite at its pointer
    for (int p = 0; p < 3; p++) begin
      rx_log = {};
      host.page_write(p[0], p[1], 16'(p + 5));
      nframes += p[1] ? 3 : 2;
      check("write bytes", rx_log.size(), p[1] ? 10 : 7);
      check("rewrite op", cmd.opcode, host.REWRITE_OP);
      check("rewrite page", rx_log[rx_log.size()-1], p);
    end
    check("program count", host.ops_cnt, 3);
    check("refresh span", host.SECTOR_PAGES <= host.REFRESH_SPAN, 1'b1);
    cfg_512 <= 1'b1;
    @(posedge clock);
    cfg_512 <= 1'b0;
    repeat (2) @(posedge clock);
    check("page size", page_bytes, 32'h200);
    check("frame ends", end_cnt, nframes);
    check("opcodes seen", cv_cnt, nframes);
    stop_test();
  end
endmodule // testbench

`default_nettype wire
